// ===== testbench/test_vdram_ctl.sv
// Self-checking bench for the video memory controller
`timescale 1ns/1ps
`default_nettype none
module test_vdram_ctl;
   import vdram_ctl_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] sw_addr = 4'h0;
   logic [15:0] sw_wdata = 16'h0000;
   logic sw_write = 1'b0;
   logic sw_read = 1'b0;
   logic shift_clock = 1'b0;
   logic [15:0] sw_rdata, dq_in, dq_out, dq_oe, color, pm, v;
   logic half;
   logic old_mask;
   logic [8:0] stop_reg, row, cbr, n0, r, c;
   logic [7:0] cm;
   pin_bundle_type mem_pins;
   int n_fail = 0;
   int comparisons = 0;
   int seed = 32'hdcc1;
   int acts, i, k;
   // Short refresh spacing keeps the run brief
   vdram_ctl #(.refresh_spacing(50), .self_refresh_hold(20)) i_vdram_ctl (
      .clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata),
      .mem_pins(mem_pins), .data_mask_pins_in(dq_in),
      .data_mask_pins_out(dq_out), .data_mask_pins_oe(dq_oe),
      .shift_clock(shift_clock), .half_indicator(half));
   vdram_model i_vdram_model (.pins(mem_pins), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(dq_in), .half(half), .old_mask(old_mask),
      .stop_reg(stop_reg), .row(row), .cbr_count(cbr), .acts(acts));
   initial forever #20 clk = ~clk;
   always @(posedge clk) shift_clock <= ~shift_clock;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Bus tasks start just after a rising edge; a gap cycle follows a write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_write <= 1'b1;
      @(posedge clk);
      sw_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      sw_addr <= a;
      sw_read <= 1'b1;
      @(posedge clk);
      sw_read <= 1'b0;
      #1 d = sw_rdata;
      @(posedge clk);
   endtask
   task automatic idle;
      int j;
      logic [15:0] s;
      for (j = 0; j < 400; j++) begin
         rd(addr_status, s);
         if (s[0] === 1'b0) break;
      end
      check({15'h0, s[0]}, 16'h0);
   endtask
   task automatic op(input command_type cmd, input logic [8:0] ra,
      input logic [8:0] ca, input logic [15:0] d, input logic [15:0] m);
      wr(addr_row, {7'h00, ra});
      wr(addr_column, {7'h00, ca});
      wr(addr_data, d);
      wr(addr_mask, m);
      idle;
      wr(addr_command, {12'h000, cmd});
      idle;
   endtask
   task automatic get(input logic [8:0] ra, input logic [8:0] ca);
      op(cmd_read, ra, ca, 16'h0000, 16'hFFFF);
      rd(addr_read_data, v);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      check(16'(mem_pins), 16'(pins_idle));
      check(dq_oe, 16'h0000);
      reset <= 1'b0;
      @(posedge clk);
      // Auto refresh off so no command write is lost to a refresh
      wr(addr_control, 16'h0001);
      rd(addr_status, v);
      check(16'(v[1]), 16'h0);
      for (i = 0; i < 3; i++) begin
         color = $random(seed);
         pm = $random(seed);
         v = $random(seed);
         cm = v[15:8];
         r = {1'b0, i[1:0], v[5:0]};
         c = {v[7:6], v[12:6]};
         op(cmd_load_color, r, c, color, 16'hFFFF);
         op(cmd_block_write, r, c, {8'h00, cm}, 16'hFFFF);
         op(cmd_masked_block_write, r ^ 9'h100, c, {8'h00, cm}, pm);
         for (k = 0; k < 8; k++) begin
            get(r, (c & block_column_mask) | 9'(k));
            check(v, cm[k] ? color : 16'h0);
            get(r ^ 9'h100, (c & block_column_mask) | 9'(k));
            check(v, cm[k] ? color & pm : 16'h0);
         end
         op(cmd_write, r, c, pm, 16'hFFFF);
         get(r, c);
         check(v, pm);
      end
      op(cmd_load_mask, r, c, pm, 16'hFFFF);
      rd(addr_status, v);
      check(16'(v[1]), 16'h1);
      op(cmd_masked_block_write, 9'h1F0, 9'h000, 16'h00FF, ~pm);
      get(9'h1F0, 9'h005);
      check(v, color & pm);
      n0 = cbr;
      op(cmd_refresh_set_stop, r, c, 16'h0000, 16'hFFFF);
      check(16'(stop_reg), 16'(r));
      op(cmd_refresh_only, ~r, c, 16'h0000, 16'hFFFF);
      rd(addr_status, v);
      check(16'({v[1], stop_reg}), 16'({1'b1, r}));
      op(cmd_refresh_reset, r, c, 16'h0000, 16'hFFFF);
      rd(addr_status, v);
      check(16'({v[1], stop_reg}), 16'h01FF);
      check(16'(cbr - n0), 16'h3);
      for (k = 0; k < 2; k++) begin
         op(cmd_read_transfer, r, {k[0], cm}, 16'h0000, 16'hFFFF);
         repeat (4) @(posedge clk);
         rd(addr_status, v);
         check(16'(v[2]), 16'(k));
      end
      op(cmd_row_only_refresh, ~r, c, 16'h0000, 16'hFFFF);
      check(16'(row), {7'h00, ~r});
      wr(addr_command, {12'h000, cmd_self_refresh});
      repeat (30) @(posedge clk);
      check(16'({mem_pins.row_strobe_n, mem_pins.column_strobe_n}), 16'h0);
      wr(addr_command, {12'h000, cmd_idle});
      idle;
      check(16'({mem_pins.row_strobe_n, mem_pins.column_strobe_n}), 16'h3);
      rd(4'hF, v);
      check(v, 16'h0000);
      wr(addr_control, 16'h0003);
      i = acts;
      repeat (500) @(posedge clk);
      check(16'(acts - i >= 9), 16'h1);
      finish_test;
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      finish_test;
   end
endmodule
`default_nettype wire

// ===== testbench/vdram_ctl_monitor.sv
// Port checker for the video memory controller
`timescale 1ns/1ps
`default_nettype none
module vdram_ctl_monitor
   import vdram_ctl_pkg::*;
#(parameter int refresh_spacing = 390) (
   // Clock, reset, software port
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   input wire logic [15:0] sw_rdata,
   // Memory side
   input wire pin_bundle_type mem_pins,
   input wire logic [15:0] data_mask_pins_in,
   input wire logic [15:0] data_mask_pins_out,
   input wire logic [15:0] data_mask_pins_oe,
   input wire logic shift_clock,
   input wire logic half_indicator
);
   logic row_d_ff, fs_row_ff, ena_ff;
   logic [15:0] gap_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Select level seen at the row strobe fall
   always_ff @(posedge clk) begin
      row_d_ff <= mem_pins.row_strobe_n;
      if (row_d_ff && !mem_pins.row_strobe_n)
         fs_row_ff <= mem_pins.function_select_pin;
   end
   // Auto refresh enable mirrors control bit 1
   always_ff @(posedge clk) begin
      if (reset)
         ena_ff <= 1'b1;
      else if (sw_write && sw_addr == addr_control)
         ena_ff <= sw_wdata[1];
   end
   // Cycles since the last row activity; only meaningful with auto refresh
   always_ff @(posedge clk)
      gap_ff <= (reset || !ena_ff || !mem_pins.row_strobe_n) ? 16'h0
         : gap_ff + 16'h1;
   AST_RESET_IDLE: assert property (disable iff (1'b0) reset ##1 reset |->
      mem_pins == pins_idle && data_mask_pins_oe == 16'h0)
      else $error("pins not idle in reset");
   AST_RDATA_QUIET: assert property (!sw_read |=> sw_rdata == 16'h0)
      else $error("read data outside its cycle");
   AST_OE_GATE: assert property (|data_mask_pins_oe |->
      mem_pins.transfer_gate_n) else $error("driving with output on");
   AST_XFER_FULL: assert property ($fell(mem_pins.row_strobe_n) &&
      !mem_pins.transfer_gate_n |-> mem_pins.column_strobe_n &&
      mem_pins.write_enable_mask_pin_n && !mem_pins.function_select_pin)
      else $error("bad transfer decode");
   AST_BLOCK_COLUMN: assert property ($fell(mem_pins.column_strobe_n) &&
      !mem_pins.row_strobe_n && mem_pins.function_select_pin && !fs_row_ff
      |-> mem_pins.address[2:0] == 3'h0) else $error("block column low bits");
   AST_BLOCK_MASK: assert property ($fell(mem_pins.column_strobe_n) &&
      !mem_pins.row_strobe_n && mem_pins.function_select_pin && !fs_row_ff
      |-> data_mask_pins_oe[7:0] == 8'hFF) else $error("column mask absent");
   AST_COLOR_DRIVE: assert property ($fell(mem_pins.column_strobe_n) &&
      !mem_pins.row_strobe_n && mem_pins.function_select_pin && fs_row_ff
      |-> data_mask_pins_oe == 16'hFFFF) else $error("color bytes absent");
   AST_ROW_HOLD: assert property ($fell(mem_pins.row_strobe_n) |->
      !mem_pins.row_strobe_n [*2]) else $error("row strobe too short");
   AST_REFRESH_GAP: assert property (gap_ff < 16'(4 * refresh_spacing))
      else $error("refresh overdue");
endmodule
bind vdram_ctl vdram_ctl_monitor #(.refresh_spacing(refresh_spacing))
   i_vdram_ctl_monitor (.clk(clk), .reset(reset), .sw_addr(sw_addr),
   .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
   .sw_rdata(sw_rdata), .mem_pins(mem_pins),
   .data_mask_pins_in(data_mask_pins_in),
   .data_mask_pins_out(data_mask_pins_out),
   .data_mask_pins_oe(data_mask_pins_oe), .shift_clock(shift_clock),
   .half_indicator(half_indicator));
`default_nettype wire

// ===== testbench/vdram_model.sv
// Behavioural model of the video memory random-access port
`timescale 1ns/1ps
`default_nettype none
module vdram_model
   import vdram_ctl_pkg::*;
#(parameter logic [8:0] stop_default = 9'h1FF) (
   // Pins from the controller
   input wire pin_bundle_type pins,
   input wire logic [15:0] dq_out,
   input wire logic [15:0] dq_oe,
   // Resolved data pins and visible device state
   output logic [15:0] dq_in,
   output logic half,
   output logic old_mask,
   output logic [8:0] stop_reg,
   output logic [8:0] row,
   output logic [8:0] cbr_count,
   output int acts
);
   bit [15:0] mem [0:511][0:511];
   logic [15:0] color, mask_reg, plane_mask, rd;
   logic fs_r, we_r, cas_r, gate_r, rd_cyc;
   logic [8:0] base;
   int k, p;
   wire logic [15:0] dq = dq_out & dq_oe;
   wire logic drive = rd_cyc && !pins.row_strobe_n &&
      !pins.column_strobe_n && !pins.transfer_gate_n;
   // Released pins outside a read cycle show the inverse, so stale data cannot pass
   assign dq_in = (dq_oe & dq_out) | (~dq_oe & (drive ? rd : ~rd));
   initial begin
      old_mask = 1'b0;
      stop_reg = stop_default;
      half = 1'b0;
      cbr_count = 9'h0;
      acts = 0;
      rd_cyc = 1'b0;
      rd = 16'h0;
   end
   // Row strobe fall decodes the cycle kind
   always @(negedge pins.row_strobe_n) begin
      // Let pins launched on the same edge settle first
      #1;
      row = pins.address;
      fs_r = pins.function_select_pin;
      we_r = pins.write_enable_mask_pin_n;
      cas_r = pins.column_strobe_n;
      gate_r = pins.transfer_gate_n;
      acts++;
      rd_cyc = 1'b0;
      plane_mask = 16'hFFFF;
      if (!cas_r) begin
         cbr_count++;
         if (!fs_r) begin
            old_mask = 1'b0;
            stop_reg = stop_default;
         end else if (!we_r)
            stop_reg = pins.address;
      end else if (!we_r && !fs_r)
         plane_mask = old_mask ? mask_reg : dq;
   end
   // Column strobe fall inside an open row
   always @(negedge pins.column_strobe_n)
      #1 if (!pins.row_strobe_n) begin
      base = pins.address & block_column_mask;
      if (!gate_r) begin
         if (cas_r && we_r && !fs_r)
            half = pins.address[8];
      end else if (fs_r && pins.function_select_pin)
         color = dq;
      else if (fs_r && we_r) begin
         mask_reg = dq;
         old_mask = 1'b1;
      end else if (pins.function_select_pin) begin
         for (k = 0; k < 8; k++)
            for (p = 0; p < 16; p++)
               if (dq[k] && plane_mask[p])
                  mem[row][base + 9'(k)][p] = color[p];
      end else if (!pins.write_enable_mask_pin_n)
         mem[row][pins.address] = (mem[row][pins.address] & ~plane_mask)
            | (dq & plane_mask);
      else begin
         rd = mem[row][pins.address];
         rd_cyc = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/vdram_ctl.sv
// Controller that drives the video memory random-access port
//
// Summary of operation
// - Color load: function select high both edges
// - Block write: select low, then high
// - Masked block: select, write low at row
// - New mask presented at masked block row fall, unless old mask set
// - Refresh all 512 rows every 8 ms
// - Row-only refresh: column strobe stays high
// - Transfer starts with gate low at row fall
// - Gate rises after column fall, shift aligned
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module vdram_ctl
   import vdram_ctl_pkg::*;
#(
   parameter int refresh_spacing = refresh_spacing_cycles,
   parameter int self_refresh_hold = self_refresh_cycles
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Software port
   input wire logic [3:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   output logic [15:0] sw_rdata,
   // Memory control pins
   output pin_bundle_type mem_pins,
   // Data and mask pins, three signals
   input wire logic [15:0] data_mask_pins_in,
   output logic [15:0] data_mask_pins_out,
   output logic [15:0] data_mask_pins_oe,
   // Device status
   input wire logic shift_clock,
   input wire logic half_indicator
);
   typedef enum logic [3:0] {
      st_idle, st_row_fall, st_col_fall, st_col_hold, st_col_rise,
      st_precharge, st_cbr_setup, st_cbr_hold
   } state_type;

   state_type state_ff;
   command_type cmd_ff;
   logic [8:0] row_ff, col_ff, refresh_row_ff;
   logic [15:0] data_ff, mask_ff, rdata_ff;
   logic old_mask_ff, auto_refresh_ff, refresh_due_ff, pending_ff;
   logic page_ff, page_next_ff;
   logic [7:0] phase_ff;
   logic [31:0] refresh_cnt_ff, hold_cnt_ff;
   logic [1:0] half_sync_ff, shift_sync_ff;
   logic half_seen_ff;

   // Two-flop synchronisers for device pins
   always_ff @(posedge clk) begin
      if (reset) begin
         half_sync_ff <= 2'h0;
         shift_sync_ff <= 2'h0;
      end else begin
         half_sync_ff <= {half_sync_ff[0], half_indicator};
         shift_sync_ff <= {shift_sync_ff[0], shift_clock};
      end
   end

   // Function: is this command one of the refresh forms led by column strobe
   function automatic logic is_cbr(input command_type c);
      return c == cmd_refresh_reset || c == cmd_refresh_only ||
         c == cmd_refresh_set_stop || c == cmd_self_refresh;
   endfunction

   // Phase counter paces each strobe step except the refresh hold
   logic phase_done;
   assign phase_done = (phase_ff == 8'(phase_cycles - 1));

   // Refresh timer: one row due per spacing interval
   always_ff @(posedge clk) begin
      if (reset) begin
         refresh_cnt_ff <= 32'h0;
         refresh_due_ff <= 1'b0;
      end else begin
         if (refresh_cnt_ff == 32'(refresh_spacing - 1)) begin
            refresh_cnt_ff <= 32'h0;
            refresh_due_ff <= 1'b1;
         end else begin
            refresh_cnt_ff <= refresh_cnt_ff + 32'h1;
            // Set wins: clear only when no new tick arrives
            if (state_ff == st_cbr_setup && auto_refresh_ff)
               refresh_due_ff <= 1'b0;
         end
      end
   end

   // Software writes and command launch
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_ff <= cmd_idle;
         row_ff <= 9'h000;
         col_ff <= 9'h000;
         data_ff <= 16'h0000;
         mask_ff <= 16'hFFFF;
         pending_ff <= 1'b0;
         page_ff <= 1'b0;
      end else begin
         if (sw_write && sw_addr == addr_row)
            row_ff <= sw_wdata[8:0];
         if (sw_write && sw_addr == addr_column)
            col_ff <= sw_wdata[8:0];
         if (sw_write && sw_addr == addr_data)
            data_ff <= sw_wdata;
         if (sw_write && sw_addr == addr_mask)
            mask_ff <= sw_wdata;
         if (sw_write && sw_addr == addr_control)
            page_ff <= sw_wdata[0];
         if (sw_write && sw_addr == addr_command && !pending_ff) begin
            cmd_ff <= command_type'(sw_wdata[3:0]);
            pending_ff <= 1'b1;
         end else if (state_ff == st_idle && pending_ff &&
               !(refresh_due_ff && auto_refresh_ff && !page_next_ff)) begin
            pending_ff <= 1'b0;
         end else if (state_ff == st_col_rise && page_next_ff) begin
            pending_ff <= 1'b0;
         end
      end
   end

   // Control bits: automatic refresh enable
   always_ff @(posedge clk) begin
      if (reset)
         auto_refresh_ff <= 1'b1;
      else if (sw_write && sw_addr == addr_control)
         auto_refresh_ff <= sw_wdata[1];
   end

   // Controller's view of mask mode in the device
   always_ff @(posedge clk) begin
      if (reset)
         old_mask_ff <= 1'b0;
      else if (state_ff == st_col_fall && cmd_ff == cmd_load_mask)
         old_mask_ff <= 1'b1;
      else if (state_ff == st_cbr_setup && cmd_ff == cmd_refresh_reset)
         old_mask_ff <= 1'b0;
   end

   // Strobe sequencer
   logic auto_cycle_ff;
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= st_idle;
         phase_ff <= 8'h00;
         mem_pins <= pins_idle;
         data_mask_pins_out <= 16'h0000;
         data_mask_pins_oe <= 16'h0000;
         refresh_row_ff <= 9'h000;
         hold_cnt_ff <= 32'h0;
         auto_cycle_ff <= 1'b0;
         page_next_ff <= 1'b0;
         rdata_ff <= 16'h0000;
      end else begin
         phase_ff <= phase_done ? 8'h00 : phase_ff + 8'h01;
         unique case (state_ff)
            st_idle: begin
               phase_ff <= 8'h00;
               mem_pins <= pins_idle;
               data_mask_pins_oe <= 16'h0000;
               if (refresh_due_ff && auto_refresh_ff) begin
                  // Row-only refresh walks rows itself
                  auto_cycle_ff <= 1'b1;
                  mem_pins.address <= refresh_row_ff;
                  refresh_row_ff <= refresh_row_ff + 9'h001;
                  state_ff <= st_cbr_setup;
               end else if (pending_ff && cmd_ff != cmd_idle) begin
                  auto_cycle_ff <= 1'b0;
                  page_next_ff <= page_ff;
                  if (is_cbr(cmd_ff) || cmd_ff == cmd_row_only_refresh) begin
                     // Row-only refresh never lowers the column strobe
                     mem_pins.column_strobe_n <=
                        (cmd_ff == cmd_row_only_refresh);
                     auto_cycle_ff <= (cmd_ff == cmd_row_only_refresh);
                     mem_pins.address <= row_ff;
                     state_ff <= st_cbr_setup;
                  end else begin
                     mem_pins.address <= row_ff;
                     // Transfer gate low at row fall starts a copy
                     mem_pins.transfer_gate_n <=
                        (cmd_ff != cmd_read_transfer);
                     // Write pin doubles as mask enable at row fall
                     mem_pins.write_enable_mask_pin_n <=
                        !(cmd_ff == cmd_masked_block_write ||
                          cmd_ff == cmd_write && mask_ff != 16'hFFFF);
                     mem_pins.function_select_pin <=
                        (cmd_ff == cmd_load_color ||
                         cmd_ff == cmd_load_mask);
                     if (cmd_ff == cmd_masked_block_write && !old_mask_ff) begin
                        data_mask_pins_out <= mask_ff;
                        data_mask_pins_oe <= 16'hFFFF;
                     end
                     state_ff <= st_row_fall;
                  end
               end
            end
            st_cbr_setup: if (phase_done) begin
               if (auto_cycle_ff) begin
                  mem_pins.row_strobe_n <= 1'b0;
               end else begin
                  // Option pins sampled at the row fall
                  mem_pins.function_select_pin <=
                     (cmd_ff != cmd_refresh_reset);
                  mem_pins.write_enable_mask_pin_n <=
                     (cmd_ff != cmd_refresh_set_stop);
                  mem_pins.row_strobe_n <= 1'b0;
               end
               hold_cnt_ff <= 32'h0;
               state_ff <= st_cbr_hold;
            end
            st_cbr_hold: begin
               hold_cnt_ff <= hold_cnt_ff + 32'h1;
               // Self refresh needs the row strobe held just past 100 us
               if (cmd_ff == cmd_self_refresh && !auto_cycle_ff) begin
                  if (hold_cnt_ff >= 32'(self_refresh_hold) &&
                        pending_ff) begin
                     mem_pins.row_strobe_n <= 1'b1;
                     mem_pins.column_strobe_n <= 1'b1;
                     state_ff <= st_precharge;
                  end
               end else if (hold_cnt_ff >= 32'(2 * phase_cycles)) begin
                  mem_pins.row_strobe_n <= 1'b1;
                  mem_pins.column_strobe_n <= 1'b1;
                  state_ff <= st_precharge;
               end
            end
            st_row_fall: if (phase_done) begin
               mem_pins.row_strobe_n <= 1'b0;
               state_ff <= st_col_fall;
            end
            st_col_fall: if (phase_done) begin
               mem_pins.address <= (cmd_ff == cmd_block_write ||
                  cmd_ff == cmd_masked_block_write) ?
                  (col_ff & block_column_mask) : col_ff;
               mem_pins.function_select_pin <=
                  (cmd_ff == cmd_load_color || cmd_ff == cmd_block_write ||
                   cmd_ff == cmd_masked_block_write);
               mem_pins.write_enable_mask_pin_n <= (cmd_ff == cmd_read ||
                  cmd_ff == cmd_read_transfer);
               // Writes keep outputs off with the gate high
               if (cmd_ff != cmd_read_transfer)
                  mem_pins.transfer_gate_n <= (cmd_ff != cmd_read);
               if (cmd_ff != cmd_read && cmd_ff != cmd_read_transfer) begin
                  data_mask_pins_out <= data_ff;
                  data_mask_pins_oe <= 16'hFFFF;
               end else begin
                  data_mask_pins_oe <= 16'h0000;
               end
               mem_pins.column_strobe_n <= 1'b0;
               state_ff <= st_col_hold;
            end
            st_col_hold: begin
               if (phase_done && cmd_ff == cmd_read)
                  rdata_ff <= data_mask_pins_in;
               // Real time copy: release gate on a shift clock rise
               if (cmd_ff == cmd_read_transfer) begin
                  if (phase_done && shift_sync_ff == 2'b01) begin
                     mem_pins.transfer_gate_n <= 1'b1;
                     state_ff <= st_col_rise;
                  end else if (phase_done)
                     phase_ff <= phase_ff; // Hold met, wait for the rise
               end else if (phase_done)
                  state_ff <= st_col_rise;
            end
            st_col_rise: if (phase_done) begin
               mem_pins.column_strobe_n <= 1'b1;
               mem_pins.transfer_gate_n <= 1'b1;
               data_mask_pins_oe <= 16'h0000;
               // Fast page: keep the row open for the next column
               if (page_next_ff && pending_ff && !is_cbr(cmd_ff))
                  state_ff <= st_col_fall;
               else begin
                  mem_pins.row_strobe_n <= 1'b1;
                  state_ff <= st_precharge;
               end
            end
            st_precharge: if (phase_done) begin
               mem_pins <= pins_idle;
               state_ff <= st_idle;
            end
            default: state_ff <= st_idle;
         endcase
      end
   end

   // Read port, data one cycle after strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         sw_rdata <= 16'h0000;
         half_seen_ff <= 1'b0;
      end else begin
         half_seen_ff <= half_sync_ff[1];
         sw_rdata <= 16'h0000;
         if (sw_read) begin
            unique case (sw_addr)
               addr_status: begin
                  sw_rdata[status_busy_bit] <= pending_ff ||
                     state_ff != st_idle;
                  sw_rdata[status_old_mask_bit] <= old_mask_ff;
                  sw_rdata[status_half_bit] <= half_seen_ff;
                  sw_rdata[status_refresh_due_bit] <= refresh_due_ff;
               end
               addr_read_data: sw_rdata <= rdata_ff;
               addr_row: sw_rdata <= {7'h00, row_ff};
               addr_column: sw_rdata <= {7'h00, col_ff};
               addr_data: sw_rdata <= data_ff;
               addr_mask: sw_rdata <= mask_ff;
               addr_control: sw_rdata <= {14'h0000, auto_refresh_ff, page_ff};
               default: sw_rdata <= 16'h0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/vdram_ctl_pkg.sv
// Package for the video memory port controller: commands, timing, pin bundle
package vdram_ctl_pkg;
   // Command codes written by software
   typedef enum logic [3:0] {
      cmd_read, cmd_write, cmd_block_write, cmd_masked_block_write,
      cmd_load_color, cmd_load_mask, cmd_row_only_refresh,
      cmd_refresh_reset, cmd_refresh_only, cmd_refresh_set_stop,
      cmd_read_transfer, cmd_self_refresh, cmd_idle
   } command_type;

   // Software register offsets (word addresses on the plain port)
   localparam logic [3:0] addr_command = 4'h0;
   localparam logic [3:0] addr_row = 4'h1;
   localparam logic [3:0] addr_column = 4'h2;
   localparam logic [3:0] addr_data = 4'h3;
   localparam logic [3:0] addr_mask = 4'h4;
   localparam logic [3:0] addr_status = 4'h5;
   localparam logic [3:0] addr_read_data = 4'h6;
   localparam logic [3:0] addr_control = 4'h7;

   // Status field positions
   localparam int status_busy_bit = 0;
   localparam int status_old_mask_bit = 1;
   localparam int status_half_bit = 2;
   localparam int status_refresh_due_bit = 3;

   // Geometry
   localparam int rows = 512;
   localparam logic [8:0] block_column_mask = 9'h1F8;
   localparam logic [8:0] last_row = 9'h1FF;

   // Timing at 25 MHz clock
   localparam int clk_mhz = 25;
   localparam int strobe_phase_ns = 80;
   localparam int phase_cycles = (strobe_phase_ns * clk_mhz + 999) / 1000;
   localparam int refresh_window_ms = 8;
   localparam int refresh_window_cycles = refresh_window_ms * clk_mhz * 1000;
   localparam int refresh_spacing_cycles = refresh_window_cycles / rows;
   localparam int self_refresh_us = 100;
   localparam int self_refresh_cycles = self_refresh_us * clk_mhz + 1;

   // Pins driven towards the memory
   typedef struct packed {
      logic row_strobe_n;
      logic column_strobe_n;
      logic transfer_gate_n;
      logic write_enable_mask_pin_n;
      logic function_select_pin;
      logic [8:0] address;
   } pin_bundle_type;

   localparam pin_bundle_type pins_idle = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
      9'h000};
endpackage
